// >>> pkg/queue_flag_defines.svh
// Offsets, pin positions, reset values and widths for the queue flag block.
// Assumes inclusion by bare name from the design file only.
`ifndef QUEUE_FLAG_DEFINES_SVH
`define QUEUE_FLAG_DEFINES_SVH

`define QF_CFG_ADDR 4'h0
`define QF_POLL_ADDR 4'h4
`define QF_STAT_ADDR 4'h8
`define QF_POLL_RST 3'h0
`define QF_RESP_OKAY 2'h0
`define QF_RESP_SLVERR 2'h2
`define QF_X9_BITS 9

`define QF_PIN_RCLK 0
`define QF_PIN_WCLK 1
`define QF_PIN_RSTB 2
`define QF_PIN_WSTB 3
`define QF_PIN_ESTB 4
`define QF_PIN_FSTB 5
`define QF_PIN_OEN 6
`define QF_PIN_MASTER_SELECT 7
`define QF_PIN_WIDTH 8
`define QF_PIN_FMODE 9
`define QF_PIN_RADDR 10
`define QF_PIN_WADDR 16
`define QF_PIN_DEVID 21
`define QF_PIN_COUNT 24

`endif

// >>> pkg/queue_flag_pkg.sv
// Types shared by the queue flag block.
// Assumes no other package.
package queue_flag_pkg;
	typedef logic [1:0] queue_t;
	typedef logic [2:0] dev_t;
	typedef enum {FLAGS_DIRECT, FLAGS_POLLED} flag_mode_e;
endpackage

// >>> sim/queue_flag_and_output_control_tb.sv
// Self-checking bench for the queue flag and output control block.
// Assumes the user model drives clock pins and selection; AXI results go through queues.
`timescale 1ns/10ps
module queue_flag_and_output_control_tb;
	logic sys_clk, rst_n, outEnableN, masterSelect, outWidthSel, flagModeSel;
	logic [2:0] deviceId;
	logic [3:0] qAlmostEmpty, qAlmostFull, qEmpty, wstrb, almostEmptyBus, almostFullBus;
	logic [17:0] rdDataIn, rdData;
	logic rdClkPin, wrClkPin, rdAddrStrobe, wrAddrStrobe, emptyBusStrobe, fullBusStrobe;
	logic [5:0] rdQueueAddr;
	logic [4:0] wrQueueAddr;
	logic rdDataOe, outValidN, outValidOe, almostEmptyN, almostFullN;
	logic almostEmptyBusOe, almostFullBusOe, fullBusSync;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	logic [33:0] rExp[$];
	logic [1:0] bExp[$];
	int fails, checked;

	queue_flag_and_output_control #(.DataWidth(18)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.rdClkPin(rdClkPin), .wrClkPin(wrClkPin), .rdQueueAddr(rdQueueAddr),
		.rdAddrStrobe(rdAddrStrobe), .wrQueueAddr(wrQueueAddr), .wrAddrStrobe(wrAddrStrobe),
		.emptyBusStrobe(emptyBusStrobe), .fullBusStrobe(fullBusStrobe), .outEnableN(outEnableN),
		.masterSelect(masterSelect), .outWidthSel(outWidthSel), .flagModeSel(flagModeSel),
		.deviceId(deviceId), .qAlmostEmpty(qAlmostEmpty), .qAlmostFull(qAlmostFull),
		.qEmpty(qEmpty), .rdDataIn(rdDataIn), .rdData(rdData), .rdDataOe(rdDataOe),
		.outValidN(outValidN), .outValidOe(outValidOe), .almostEmptyN(almostEmptyN),
		.almostFullN(almostFullN), .almostEmptyBus(almostEmptyBus),
		.almostEmptyBusOe(almostEmptyBusOe), .almostFullBus(almostFullBus),
		.almostFullBusOe(almostFullBusOe), .fullBusSync(fullBusSync), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp));

	queue_user_model i_user (.sys_clk(sys_clk), .rdClkPin(rdClkPin), .wrClkPin(wrClkPin),
		.rdQueueAddr(rdQueueAddr), .rdAddrStrobe(rdAddrStrobe), .wrQueueAddr(wrQueueAddr),
		.wrAddrStrobe(wrAddrStrobe), .emptyBusStrobe(emptyBusStrobe),
		.fullBusStrobe(fullBusStrobe));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Answers are judged when they appear, against the oldest note
	always @(posedge sys_clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			chk("rdata", rExp[0][33:2], rdata);
			chk("rresp", rExp[0][1:0], rresp);
			void'(rExp.pop_front());
		end
		if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", bExp.pop_front(), bresp);
	end

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
		int n;
		bExp.push_back(resp);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (n > 40) begin
				fails++;
				close_out();
			end
		end while (bvalid !== 1'b1);
	endtask

	task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
		int n;
		rExp.push_back({d, resp});
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
			if (n > 40) begin
				fails++;
				close_out();
			end
		end while (rvalid !== 1'b1);
	endtask

	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		close_out();
	end

	initial begin
		{rst_n, outEnableN, outWidthSel, flagModeSel, awvalid, wvalid, arvalid} = '0;
		{bready, rready, awaddr, wdata, araddr, qAlmostEmpty, qAlmostFull, qEmpty} = '0;
		masterSelect = 1'b1;
		deviceId = 3'h5;
		wstrb = 4'hf;
		rdDataIn = '0;
		void'($urandom(32'h50d2));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		axi_rd(32'h0, 32'h51, 2'h0);
		axi_rd(32'h10, 32'h0, 2'h2);
		axi_wr(32'h20, 32'h1, 2'h2);
		for (int q = 0; q < 4; q++) begin
			qAlmostEmpty <= 4'($urandom);
			qAlmostFull <= 4'($urandom);
			qEmpty <= 4'($urandom);
			rdDataIn <= 18'($urandom);
			// Selections land on one edge; almost flags show from the next one, output-valid from the one after
			i_user.rd_edge({3'h5, 1'b0, 2'(q)}, 1'b1, 1'b0);
			i_user.wr_edge({3'h5, 2'(q)}, 1'b1, 1'b1);
			i_user.wr_edge({3'h5, 2'(q)}, 1'b0, 1'b0);
			chk("almostFullN", !qAlmostFull[q], almostFullN);
			chk("afBus", {1'b1, ~qAlmostFull}, {almostFullBusOe, almostFullBus});
			i_user.rd_edge({3'h5, 1'b0, 2'(q)}, 1'b0, 1'b1);
			chk("almostEmptyN", !qAlmostEmpty[q], almostEmptyN);
			i_user.rd_edge({3'h5, 1'b0, 2'(q)}, 1'b0, 1'b0);
			chk("outValidN", qEmpty[q], outValidN);
			chk("rdData", rdDataIn, rdData);
			chk("aeBus", {1'b1, ~qAlmostEmpty}, {almostEmptyBusOe, almostEmptyBus});
		end
		i_user.rd_edge({3'h2, 3'h0}, 1'b0, 1'b1);
		i_user.wr_edge({3'h2, 2'h0}, 1'b1, 1'b1);
		i_user.rd_edge({3'h2, 3'h0}, 1'b1, 1'b0);
		chk("aeBusOe", 1'b0, almostEmptyBusOe);
		i_user.wr_edge({3'h2, 2'h0}, 1'b0, 1'b0);
		chk("afBusOe", 1'b0, almostFullBusOe);
		chk("almostFullN", 1'b1, almostFullN);
		repeat (2) i_user.rd_edge({3'h2, 3'h0}, 1'b0, 1'b0);
		chk("outValidN", 1'b1, outValidN);
		chk("almostEmptyN", 1'b1, almostEmptyN);
		chk("rdDataOe", 1'b1, rdDataOe);
		chk("outValidOe", 1'b1, outValidOe);
		outEnableN <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("rdDataOe", 1'b0, rdDataOe);
		// Straps move well before reset so the synchroniser settles on them
		masterSelect <= 1'b0;
		outWidthSel <= 1'b1;
		flagModeSel <= 1'b1;
		deviceId <= 3'h0;
		outEnableN <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("rdDataOe", 1'b0, rdDataOe);
		chk("outValidOe", 1'b0, outValidOe);
		axi_rd(32'h0, 32'h6, 2'h0);
		axi_wr(32'h4, 32'h1, 2'h0);
		axi_rd(32'h4, 32'h1, 2'h0);
		for (int i = 0; i < 4; i++) begin
			i_user.wr_edge(5'h0, 1'b0, 1'b0);
			chk("fullBusSync", i % 2 == 0, fullBusSync);
			chk("afBusOe", i % 2 == 0, almostFullBusOe);
			i_user.rd_edge(6'h0, 1'b0, 1'b0);
			chk("aeBusOe", i % 2 == 0, almostEmptyBusOe);
		end
		i_user.rd_edge(6'h2, 1'b1, 1'b0);
		repeat (5) @(posedge sys_clk);
		chk("rdDataOe", 1'b1, rdDataOe);
		chk("rdData", {9'h0, rdDataIn[8:0]}, rdData);
		close_out();
	end
endmodule

// >>> sim/queue_user_model.sv
// User logic beside the queue flag block: clock pins, queue selection and bus strobes.
// Assumes the caller enters each task just after a rising sys_clk edge.
`timescale 1ns/10ps
module queue_user_model (
	input wire logic sys_clk,
	output logic rdClkPin,
	output logic wrClkPin,
	output logic [5:0] rdQueueAddr,
	output logic rdAddrStrobe,
	output logic [4:0] wrQueueAddr,
	output logic wrAddrStrobe,
	output logic emptyBusStrobe,
	output logic fullBusStrobe
);
	initial begin
		rdClkPin = 1'b0;
		wrClkPin = 1'b0;
		rdQueueAddr = 6'h3f;
		rdAddrStrobe = 1'b0;
		wrQueueAddr = 5'h1f;
		wrAddrStrobe = 1'b0;
		emptyBusStrobe = 1'b0;
		fullBusStrobe = 1'b0;
	end

	// Pins are synchronised by the block, so each level is held five sys_clk cycles
	task automatic rd_edge(input logic [5:0] addr, input logic sel, input logic busSel);
		rdQueueAddr <= addr;
		rdAddrStrobe <= sel;
		emptyBusStrobe <= busSel;
		rdClkPin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rdClkPin <= 1'b0;
		rdAddrStrobe <= 1'b0;
		emptyBusStrobe <= 1'b0;
		rdQueueAddr <= ~addr;
		repeat (5) @(posedge sys_clk);
	endtask

	task automatic wr_edge(input logic [4:0] addr, input logic sel, input logic busSel);
		wrQueueAddr <= addr;
		wrAddrStrobe <= sel;
		fullBusStrobe <= busSel;
		wrClkPin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		wrClkPin <= 1'b0;
		wrAddrStrobe <= 1'b0;
		fullBusStrobe <= 1'b0;
		wrQueueAddr <= ~addr;
		repeat (5) @(posedge sys_clk);
	endtask
endmodule

// >>> verilog/queue_flag_and_output_control.sv
// Read-port output control and queue flag logic of a four-queue buffer.
// Assumes queue status and read data come from logic on sys_clk; pins are async.
//
// How it works
// - Output enable pin steers read bus drive with no reference to read/write clocks.
// - Master drives read bus while output enable low, releases it while high.
// - Slave keeps read bus released until selected on read port, then follows enable.
// - Output-valid flag follows a new read queue two read clock edges later.
// - Output-valid goes high when the selected read queue is empty.
// - Output-valid pin can be released for wired expansion.
// - Width strap caught at reset: low gives 18-bit, high gives 9-bit read bus.
// - Almost-empty pin low on read edges while the selected read queue is almost empty.
// - Four-bit almost-empty bus carries one bit per queue, direct or polled.
// - Flag mode strap caught at reset picks direct or polled for both buses.
// - Direct almost-empty bus shows device picked by read edge, strobe and address.
// - Polled almost-empty bus steps to the next device on every read edge.
// - Almost-full pin low on write edges while the selected write queue is almost full.
// - Four-bit almost-full bus carries one bit per queue, direct or polled.
// - Direct almost-full bus shows device picked by write edge, strobes and address.
// - Polled almost-full bus steps to the next device on every write edge.
// - Both flag buses can be released so expanded devices share them.
// - Master strap high at reset makes master; slaves start with outputs released.
// - Full-bus sync is high in polled mode for the write cycle carrying this device's status; it stays low in direct mode.
`timescale 1ns/10ps
`include "queue_flag_defines.svh"

module queue_flag_and_output_control #(
	parameter int DataWidth = 18
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rdClkPin,
	input wire logic wrClkPin,
	input wire logic [5:0] rdQueueAddr,
	input wire logic rdAddrStrobe,
	input wire logic [4:0] wrQueueAddr,
	input wire logic wrAddrStrobe,
	input wire logic emptyBusStrobe,
	input wire logic fullBusStrobe,
	input wire logic outEnableN,
	input wire logic masterSelect,
	input wire logic outWidthSel,
	input wire logic flagModeSel,
	input wire logic [2:0] deviceId,
	input wire logic [3:0] qAlmostEmpty,
	input wire logic [3:0] qAlmostFull,
	input wire logic [3:0] qEmpty,
	input wire logic [DataWidth-1:0] rdDataIn,
	output logic [DataWidth-1:0] rdData,
	output logic rdDataOe,
	output logic outValidN,
	output logic outValidOe,
	output logic almostEmptyN,
	output logic almostFullN,
	output logic [3:0] almostEmptyBus,
	output logic almostEmptyBusOe,
	output logic [3:0] almostFullBus,
	output logic almostFullBusOe,
	output logic fullBusSync,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	// Pin synchroniser: three stages, a change counts once stages two and three agree
	logic [`QF_PIN_COUNT-1:0] pinRaw;
	logic [`QF_PIN_COUNT-1:0] pinS1_reg;
	logic [`QF_PIN_COUNT-1:0] pinS2_reg;
	logic [`QF_PIN_COUNT-1:0] pinS3_reg;
	logic [`QF_PIN_COUNT-1:0] pinF_reg;
	logic [`QF_PIN_COUNT-1:0] pinF_next;
	logic rdClkPrev_reg;
	logic wrClkPrev_reg;

	assign pinRaw = {deviceId, wrQueueAddr, rdQueueAddr, flagModeSel, outWidthSel, masterSelect,
		outEnableN, fullBusStrobe, emptyBusStrobe, wrAddrStrobe, rdAddrStrobe, wrClkPin, rdClkPin};
	assign pinF_next = (pinS2_reg == pinS3_reg) ? pinS3_reg : pinF_reg;

	always_ff @(posedge sys_clk) begin
		pinS1_reg <= pinRaw;
		pinS2_reg <= pinS1_reg;
		pinS3_reg <= pinS2_reg;
		pinF_reg <= pinF_next;
	end

	wire rdClkF = pinF_reg[`QF_PIN_RCLK];
	wire wrClkF = pinF_reg[`QF_PIN_WCLK];
	wire rdStbF = pinF_reg[`QF_PIN_RSTB];
	wire wrStbF = pinF_reg[`QF_PIN_WSTB];
	wire eStbF = pinF_reg[`QF_PIN_ESTB];
	wire fStbF = pinF_reg[`QF_PIN_FSTB];
	wire oeNF = pinF_reg[`QF_PIN_OEN];
	wire [5:0] rAddrF = pinF_reg[`QF_PIN_RADDR +: 6];
	wire [4:0] wAddrF = pinF_reg[`QF_PIN_WADDR +: 5];

	// Read and write clock pins become one-cycle enables of sys_clk
	wire rdRise = rdClkF && !rdClkPrev_reg;
	wire wrRise = wrClkF && !wrClkPrev_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdClkPrev_reg <= 1'b1;
			wrClkPrev_reg <= 1'b1;
		end else begin
			rdClkPrev_reg <= rdClkF;
			wrClkPrev_reg <= wrClkF;
		end
	end

	// Straps are sampled all through reset and frozen at release
	logic cfgMaster_reg;
	logic cfgX9_reg;
	queue_flag_pkg::flag_mode_e cfgMode_reg;
	queue_flag_pkg::dev_t cfgId_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cfgMaster_reg <= pinS3_reg[`QF_PIN_MASTER_SELECT];
			cfgX9_reg <= pinS3_reg[`QF_PIN_WIDTH];
			cfgMode_reg <= pinS3_reg[`QF_PIN_FMODE] ? queue_flag_pkg::FLAGS_POLLED
				: queue_flag_pkg::FLAGS_DIRECT;
			cfgId_reg <= pinS3_reg[`QF_PIN_DEVID +: 3];
		end
	end

	wire polled = (cfgMode_reg == queue_flag_pkg::FLAGS_POLLED);

	function automatic logic devHit(input logic [2:0] addrDev, input logic [2:0] ownId);
		devHit = (addrDev == ownId);
	endfunction

	function automatic logic [2:0] slotStep(input logic [2:0] slot, input logic [2:0] last);
		slotStep = (slot == last) ? 3'h0 : slot + 3'h1;
	endfunction

	// Read port queue selection
	logic rdSel_reg;
	logic rdNull_reg;
	queue_flag_pkg::queue_t rdQueue_reg;
	logic ovStage_reg;
	logic [2:0] pollLast_reg;
	logic [2:0] rdSlot_reg;
	logic [2:0] wrSlot_reg;
	logic wrSel_reg;
	queue_flag_pkg::queue_t wrQueue_reg;
	logic aeBusSel_reg;
	logic afBusSel_reg;

	wire rdPick = rdRise && rdStbF;
	wire rdPickHit = devHit(rAddrF[5:3], cfgId_reg);
	wire rdEmptyNow = !rdSel_reg || rdNull_reg || qEmpty[rdQueue_reg];
	wire [2:0] rdSlotNext = slotStep(rdSlot_reg, pollLast_reg);
	wire [2:0] wrSlotNext = slotStep(wrSlot_reg, pollLast_reg);
	wire wrPick = wrRise && wrStbF;
	wire wrPickHit = devHit(wAddrF[4:2], cfgId_reg);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdSel_reg <= 1'b0;
			rdNull_reg <= 1'b1;
			rdQueue_reg <= '0;
			ovStage_reg <= 1'b1;
			outValidN <= 1'b1;
			almostEmptyN <= 1'b1;
		end else if (rdRise) begin
			if (rdPick) begin
				rdSel_reg <= rdPickHit;
				rdNull_reg <= rAddrF[2];
				rdQueue_reg <= rAddrF[1:0];
			end
			ovStage_reg <= rdEmptyNow;
			outValidN <= ovStage_reg;
			almostEmptyN <= !(rdSel_reg && !rdNull_reg && qAlmostEmpty[rdQueue_reg]);
		end
	end

	// Read data bus and output-valid drive; enable pin is sampled, so it lags by the sync
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdData <= '0;
			rdDataOe <= 1'b0;
			outValidOe <= 1'b0;
		end else begin
			rdData <= cfgX9_reg ? {{(DataWidth-`QF_X9_BITS){1'b0}}, rdDataIn[`QF_X9_BITS-1:0]}
				: rdDataIn;
			rdDataOe <= !oeNF && (cfgMaster_reg || rdSel_reg);
			outValidOe <= cfgMaster_reg || rdSel_reg;
		end
	end

	// Almost-empty bus, direct or polled
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aeBusSel_reg <= 1'b0;
			rdSlot_reg <= '0;
			almostEmptyBus <= 4'hf;
			almostEmptyBusOe <= 1'b0;
		end else if (rdRise) begin
			if (rdRise && eStbF) begin
				aeBusSel_reg <= devHit(rAddrF[5:3], cfgId_reg);
			end
			rdSlot_reg <= rdSlotNext;
			almostEmptyBus <= ~qAlmostEmpty;
			almostEmptyBusOe <= polled ? (rdSlot_reg == cfgId_reg) : aeBusSel_reg;
		end
	end

	// Write port selection, almost-full pin and bus
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrSel_reg <= 1'b0;
			wrQueue_reg <= '0;
			afBusSel_reg <= 1'b0;
			wrSlot_reg <= '0;
			almostFullN <= 1'b1;
			almostFullBus <= 4'hf;
			almostFullBusOe <= 1'b0;
			fullBusSync <= 1'b0;
		end else if (wrRise) begin
			if (wrPick) begin
				wrSel_reg <= wrPickHit;
				wrQueue_reg <= wAddrF[1:0];
			end
			if (fStbF && wrStbF) begin
				afBusSel_reg <= wrPickHit;
			end
			wrSlot_reg <= wrSlotNext;
			almostFullN <= !(wrSel_reg && qAlmostFull[wrQueue_reg]);
			almostFullBus <= ~qAlmostFull;
			almostFullBusOe <= polled ? (wrSlot_reg == cfgId_reg) : afBusSel_reg;
			fullBusSync <= polled && (wrSlot_reg == cfgId_reg);
		end
	end

	// AXI4-Lite slave, one write and one read at a time
	logic awHeld_reg;
	logic wHeld_reg;
	logic [3:0] awAddr_reg;
	logic [2:0] wData_reg;
	logic wLane0_reg;

	wire awTake = awvalid && awready;
	wire wTake = wvalid && wready;
	wire wrDo = awHeld_reg && wHeld_reg && !bvalid;
	wire wrPoll = (awAddr_reg == `QF_POLL_ADDR);
	wire wrKnown = wrPoll || (awAddr_reg == `QF_CFG_ADDR) || (awAddr_reg == `QF_STAT_ADDR);
	wire [3:0] arOff = araddr[3:0];
	wire arKnown = (araddr[31:4] == 28'h0) &&
		((arOff == `QF_CFG_ADDR) || (arOff == `QF_POLL_ADDR) || (arOff == `QF_STAT_ADDR));
	wire [31:0] cfgWord = {25'h0, cfgId_reg, 1'b0, polled, cfgX9_reg, cfgMaster_reg};
	wire [31:0] statWord = {22'h0, aeBusSel_reg, afBusSel_reg, wrSel_reg, wrQueue_reg,
		rdSel_reg, rdNull_reg, rdQueue_reg, outValidN};
	wire [31:0] readMux = (arOff == `QF_CFG_ADDR) ? cfgWord
		: (arOff == `QF_POLL_ADDR) ? {29'h0, pollLast_reg}
		: (arOff == `QF_STAT_ADDR) ? statWord : 32'h0;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			wLane0_reg <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `QF_RESP_OKAY;
			pollLast_reg <= `QF_POLL_RST;
		end else begin
			if (awTake) begin
				awHeld_reg <= 1'b1;
				awready <= 1'b0;
				awAddr_reg <= (awaddr[31:4] == 28'h0) ? awaddr[3:0] : 4'hc;
			end
			if (wTake) begin
				wHeld_reg <= 1'b1;
				wready <= 1'b0;
				wData_reg <= wdata[2:0];
				wLane0_reg <= wstrb[0];
			end
			if (wrDo) begin
				bvalid <= 1'b1;
				bresp <= wrKnown ? `QF_RESP_OKAY : `QF_RESP_SLVERR;
				if (wrPoll && wLane0_reg) begin
					pollLast_reg <= wData_reg;
				end
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `QF_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= arKnown ? readMux : 32'h0;
			rresp <= arKnown ? `QF_RESP_OKAY : `QF_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_rdOwnEmpty;
		rdRise && rdSel_reg && !rdNull_reg && qEmpty[rdQueue_reg];
	endsequence

	property p_master_drive;
		cfgMaster_reg && !oeNF |=> rdDataOe;
	endproperty
	a_master_drive: assert property (p_master_drive) else $error("master bus not driven");

	property p_release;
		oeNF |=> !rdDataOe;
	endproperty
	a_release: assert property (p_release) else $error("bus driven with enable high");

	property p_slave_quiet;
		!cfgMaster_reg && !rdSel_reg |=> !rdDataOe;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives bus");

	property p_ov_stage;
		rdRise && ovStage_reg |=> outValidN;
	endproperty
	a_ov_stage: assert property (p_ov_stage) else $error("valid flag missed empty");

	property p_ov_two_edges;
		s_rdOwnEmpty |=> ovStage_reg;
	endproperty
	a_ov_two_edges: assert property (p_ov_two_edges) else $error("valid stage not empty");

	property p_rd_stable;
		!rdRise |=> $stable(outValidN) && $stable(almostEmptyN) && $stable(almostEmptyBus);
	endproperty
	a_rd_stable: assert property (p_rd_stable) else $error("read flag moved off edge");

	property p_wr_stable;
		!wrRise |=> $stable(almostFullN) && $stable(almostFullBus) && $stable(fullBusSync);
	endproperty
	a_wr_stable: assert property (p_wr_stable) else $error("write flag moved off edge");

	property p_ae_pin;
		rdRise && rdSel_reg && !rdNull_reg |=> almostEmptyN == !$past(qAlmostEmpty[rdQueue_reg]);
	endproperty
	a_ae_pin: assert property (p_ae_pin) else $error("almost-empty pin wrong");

	property p_sync_own;
		fullBusSync |-> polled && almostFullBusOe;
	endproperty
	a_sync_own: assert property (p_sync_own) else $error("sync outside own slot");

	property p_poll_wrap;
		rdRise && rdSlot_reg == pollLast_reg |=> rdSlot_reg == 3'h0;
	endproperty
	a_poll_wrap: assert property (p_poll_wrap) else $error("poll slot did not wrap");

	property p_x9;
		cfgX9_reg |-> rdData[DataWidth-1:`QF_X9_BITS] == '0;
	endproperty
	a_x9: assert property (p_x9) else $error("x9 bus upper bits set");

	property p_direct_miss;
		rdRise && eStbF && !devHit(rAddrF[5:3], cfgId_reg) |=> !aeBusSel_reg;
	endproperty
	a_direct_miss: assert property (p_direct_miss) else $error("picked on a miss");
endmodule
